// ### core/link_err_consts.svh
// Offsets, field positions, reset values and counts of the link error block
`ifndef LINK_ERR_CONSTS_SVH
`define LINK_ERR_CONSTS_SVH
`define ERRF_IDX 10'h0c7
`define DLY_IDX 10'h0c9
`define CTRL_IDX 10'h0d0
`define IRQ_ST_IDX 10'h0d1
`define IRQ_EN_IDX 10'h0d2
`define IRQ_CLR_IDX 10'h0d3
`define BIT_CRC 10
`define BIT_ECC2 9
`define BIT_ECC1 8
`define BIT_CMD 7
`define BIT_LONG 4
`define BIT_LANE_CONTENTION_FLAG 2
`define BIT_VCM 0
`define CTRL_CHKDIS 0
`define CTRL_PREP 1
`define CTRL_ZERO 2
`define ERRF_W1C_MASK 16'h0791
`define ERRF_USED_MASK 16'h0795
`define ERRF_RSVD_MASK 32'hffff_f86a
`define DLY_RESET 16'h1402
`define NIBBLE_DIV 4
`define PREP_INHERENT 9'h004
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### core/link_err_pkg.sv
// Types shared by the link error and delay register block
`default_nettype none
package link_err_pkg;
  typedef struct packed {
    logic crc_fail;
    logic hdr_multi_bit;
    logic hdr_single_bit;
    logic cmd_fifo_overflow;
    logic long_fifo_overflow;
    logic lane_contention;
    logic channel_id_mismatch;
  } link_evt_t;
  typedef struct packed {
    logic [7:0] hs_zero_count;
    logic [7:0] hs_prepare_count;
  } hs_delay_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_PREP = 2'b01,
    HS_ZERO = 2'b11
  } hs_phase_t;
endpackage
`default_nettype wire

// ### core/sticky_bits.sv
// Vector of sticky flags, set by hardware and cleared by writing one
`default_nettype none
module sticky_bits #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  always_comb begin
    // Set wins, so an event in the clearing cycle is kept
    nxt_q = (q_ff & ~clr) | set;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule // sticky_bits
`default_nettype wire

// ### core/hs_entry_timer.sv
// HS-prepare and HS-zero sequencer counted in nibble clocks
`include "link_err_consts.svh"
`default_nettype none
module hs_entry_timer
  import link_err_pkg::*;
#(
  parameter int DIV = `NIBBLE_DIV
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic start,
  input wire hs_delay_t counts,
  output logic prep_on,
  output logic zero_on
);
  localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
  hs_phase_t phase_ff, nxt_phase;
  logic [DW-1:0] div_ff, nxt_div;
  logic [8:0] cnt_ff, nxt_cnt;
  logic [7:0] zero_ff, nxt_zero;
  logic tick;

  // Divider restarts at each start so every period is whole nibbles
  assign tick = (div_ff == DW'(DIV - 1));

  always_comb begin
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_zero = zero_ff;
    nxt_div = (phase_ff == HS_IDLE || tick) ? '0 : div_ff + 1'b1;
    unique case (phase_ff)
      HS_IDLE: begin
        if (start) begin
          nxt_phase = HS_PREP;
          nxt_cnt = `PREP_INHERENT + {1'b0, counts.hs_prepare_count};
          nxt_zero = counts.hs_zero_count;
        end
      end
      HS_PREP: begin
        if (tick) begin
          if (cnt_ff == 9'h001) begin
            nxt_phase = (zero_ff == 8'h00) ? HS_IDLE : HS_ZERO;
            nxt_cnt = {1'b0, zero_ff};
          end else begin
            nxt_cnt = cnt_ff - 9'h001;
          end
        end
      end
      HS_ZERO: begin
        if (tick) begin
          if (cnt_ff == 9'h001) begin
            nxt_phase = HS_IDLE;
          end
          nxt_cnt = cnt_ff - 9'h001;
        end
      end
      default: begin
        nxt_phase = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= HS_IDLE;
      div_ff <= '0;
      cnt_ff <= '0;
      zero_ff <= '0;
    end else begin
      phase_ff <= nxt_phase;
      div_ff <= nxt_div;
      cnt_ff <= nxt_cnt;
      zero_ff <= nxt_zero;
    end
  end

  assign prep_on = (phase_ff == HS_PREP);
  assign zero_on = (phase_ff == HS_ZERO);

  // Helper: cycles spent in the current phase and captured prepare length
  logic [11:0] len_ff;
  logic [8:0] prep_len_ff;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      len_ff <= '0;
      prep_len_ff <= '0;
    end else begin
      len_ff <= (nxt_phase != phase_ff) ? 12'h000 : len_ff + 12'h001;
      if (phase_ff == HS_IDLE && start) begin
        prep_len_ff <= nxt_cnt;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_prep_len;
    phase_ff == HS_PREP && nxt_phase != HS_PREP |->
      len_ff == 12'(prep_len_ff * DIV - 1);
  endproperty
  a_prep_len: assert property (p_prep_len)
    else $error("HS-prepare length wrong");

  property p_zero_len;
    phase_ff == HS_ZERO && nxt_phase != HS_ZERO |->
      len_ff == 12'(zero_ff * DIV - 1);
  endproperty
  a_zero_len: assert property (p_zero_len)
    else $error("HS-zero length wrong");

  property p_nibble;
    tick && nxt_phase != HS_IDLE |=> !tick [*3] ##1 tick;
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("Nibble tick spacing wrong");

  c_prep_zero: cover property (prep_on ##1 zero_on);
endmodule // hs_entry_timer
`default_nettype wire

// ### core/link_err_regs.sv
// Link error flags, HS entry delays and AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite register port.
`include "link_err_consts.svh"
`default_nettype none
module link_err_regs
  import link_err_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire link_evt_t evt,
  input wire logic hs_entry_start,
  output logic check_disable,
  output logic hs_prepare_on,
  output logic hs_zero_on,
  output logic irq
);
  logic nrst_meta_ff, nrst_sync_ff;
  logic aw_held_ff, nxt_aw_held;
  logic w_held_ff, nxt_w_held;
  logic [9:0] wr_sel_ff, nxt_wr_sel;
  logic [15:0] wdata_ff, nxt_wdata;
  logic [1:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic wr_fire, wr_hit, rd_hit;
  logic [15:0] lane_mask, rd_val;
  hs_delay_t delay_ff, nxt_delay;
  logic check_disable_ff, nxt_check_disable;
  logic [15:0] irq_en_ff, nxt_irq_en;
  logic lane_contention_flag_ff, irq_ff, nxt_irq;
  logic [15:0] err_set, err_clr, irq_set, irq_clr, err_q, irq_q;

  // Reset released through two flops; asserted at once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nrst_meta_ff <= 1'b0;
      nrst_sync_ff <= 1'b0;
    end else begin
      nrst_meta_ff <= 1'b1;
      nrst_sync_ff <= nrst_meta_ff;
    end
  end

  // Write channel: address and data taken in either order
  assign awready = !aw_held_ff && !bvalid_ff;
  assign wready = !w_held_ff && !bvalid_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign lane_mask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

  always_comb begin
    unique case (wr_sel_ff)
      `ERRF_IDX, `DLY_IDX, `CTRL_IDX: wr_hit = 1'b1;
      `IRQ_EN_IDX, `IRQ_CLR_IDX: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_wr_sel = wr_sel_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (awvalid && awready) begin
      nxt_aw_held = 1'b1;
      nxt_wr_sel = awaddr[11:2];
    end
    if (wvalid && wready) begin
      nxt_w_held = 1'b1;
      nxt_wdata = wdata[15:0];
      nxt_wstrb = wstrb[1:0];
    end
    if (wr_fire) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst_sync_ff) begin
    if (!nrst_sync_ff) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      wr_sel_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      wr_sel_ff <= nxt_wr_sel;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // Read channel: one read in flight, data one cycle after address
  assign arready = !rvalid_ff;

  always_comb begin
    rd_hit = 1'b1;
    unique case (araddr[11:2])
      // Contention is a live level; reserved bits forced low
      `ERRF_IDX: rd_val = (err_q | (16'(evt.lane_contention) << `BIT_LANE_CONTENTION_FLAG))
        & `ERRF_USED_MASK;
      `DLY_IDX: rd_val = delay_ff;
      `CTRL_IDX: rd_val = (16'(check_disable_ff) << `CTRL_CHKDIS)
        | (16'(hs_prepare_on) << `CTRL_PREP)
        | (16'(hs_zero_on) << `CTRL_ZERO);
      `IRQ_ST_IDX: rd_val = irq_q;
      `IRQ_EN_IDX: rd_val = irq_en_ff;
      `IRQ_CLR_IDX: rd_val = 16'h0000;
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (arvalid && arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = {16'h0000, rd_val};
      nxt_rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst_sync_ff) begin
    if (!nrst_sync_ff) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= `RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // Register writes and event collection
  always_comb begin
    nxt_delay = delay_ff;
    nxt_check_disable = check_disable_ff;
    nxt_irq_en = irq_en_ff;
    err_clr = '0;
    irq_clr = '0;
    if (wr_fire) begin
      unique case (wr_sel_ff)
        `ERRF_IDX: err_clr = wdata_ff & lane_mask & `ERRF_W1C_MASK;
        `DLY_IDX: nxt_delay = (delay_ff & ~lane_mask)
          | (wdata_ff & lane_mask);
        `CTRL_IDX: begin
          if (wstrb_ff[0]) begin
            nxt_check_disable = wdata_ff[`CTRL_CHKDIS];
          end
        end
        `IRQ_EN_IDX: nxt_irq_en = ((irq_en_ff & ~lane_mask)
          | (wdata_ff & lane_mask)) & `ERRF_USED_MASK;
        `IRQ_CLR_IDX: irq_clr = wdata_ff & lane_mask;
        default: begin
        end
      endcase
    end
    // Checks disabled: header and payload errors are not recorded
    err_set = '0;
    err_set[`BIT_CRC] = evt.crc_fail && !check_disable_ff;
    err_set[`BIT_ECC2] = evt.hdr_multi_bit && !check_disable_ff;
    err_set[`BIT_ECC1] = evt.hdr_single_bit && !check_disable_ff;
    err_set[`BIT_CMD] = evt.cmd_fifo_overflow;
    err_set[`BIT_LONG] = evt.long_fifo_overflow;
    err_set[`BIT_VCM] = evt.channel_id_mismatch;
    irq_set = err_set;
    irq_set[`BIT_LANE_CONTENTION_FLAG] = evt.lane_contention && !lane_contention_flag_ff;
    nxt_irq = |(irq_q & irq_en_ff);
  end

  always_ff @(posedge clock or negedge nrst_sync_ff) begin
    if (!nrst_sync_ff) begin
      delay_ff <= `DLY_RESET;
      check_disable_ff <= 1'b0;
      irq_en_ff <= '0;
      lane_contention_flag_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      delay_ff <= nxt_delay;
      check_disable_ff <= nxt_check_disable;
      irq_en_ff <= nxt_irq_en;
      lane_contention_flag_ff <= evt.lane_contention;
      irq_ff <= nxt_irq;
    end
  end

  sticky_bits #(.W(16)) u_err_flags (
    .clock(clock),
    .nrst(nrst_sync_ff),
    .set(err_set),
    .clr(err_clr),
    .q(err_q)
  );

  sticky_bits #(.W(16)) u_irq_flags (
    .clock(clock),
    .nrst(nrst_sync_ff),
    .set(irq_set),
    .clr(irq_clr),
    .q(irq_q)
  );

  hs_entry_timer #(.DIV(`NIBBLE_DIV)) u_hs_timer (
    .clock(clock),
    .nrst(nrst_sync_ff),
    .start(hs_entry_start),
    .counts(delay_ff),
    .prep_on(hs_prepare_on),
    .zero_on(hs_zero_on)
  );

  assign check_disable = check_disable_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst_sync_ff);

  property p_crc_set;
    evt.crc_fail && !check_disable_ff |=> err_q[`BIT_CRC];
  endproperty
  a_crc_set: assert property (p_crc_set)
    else $error("CRC flag not set");

  property p_chk_gate;
    check_disable_ff && !err_q[`BIT_CRC] && !err_q[`BIT_ECC2]
      |=> !err_q[`BIT_CRC] && !err_q[`BIT_ECC2];
  endproperty
  a_chk_gate: assert property (p_chk_gate)
    else $error("Check flag set while checks disabled");

  property p_hold;
    err_q[`BIT_VCM] && !err_clr[`BIT_VCM] |=> err_q[`BIT_VCM];
  endproperty
  a_hold: assert property (p_hold)
    else $error("Sticky flag dropped without clear");

  property p_fall_cause;
    $fell(err_q[`BIT_CMD]) |-> $past(err_clr[`BIT_CMD]);
  endproperty
  a_fall_cause: assert property (p_fall_cause)
    else $error("Flag cleared without a write of one");

  property p_ecc2_set;
    evt.hdr_multi_bit && !check_disable_ff |=> err_q[`BIT_ECC2];
  endproperty
  a_ecc2_set: assert property (p_ecc2_set)
    else $error("Multi-bit flag not set");

  property p_ecc1_rise;
    $rose(err_q[`BIT_ECC1]) |->
      $past(evt.hdr_single_bit) && !$past(check_disable_ff);
  endproperty
  a_ecc1_rise: assert property (p_ecc1_rise)
    else $error("Single-bit flag rose without cause");

  property p_cmd_set;
    evt.cmd_fifo_overflow && err_clr[`BIT_CMD] |=> err_q[`BIT_CMD];
  endproperty
  a_cmd_set: assert property (p_cmd_set)
    else $error("Command overflow lost against clear");

  property p_long_set;
    evt.long_fifo_overflow |=> err_q[`BIT_LONG];
  endproperty
  a_long_set: assert property (p_long_set)
    else $error("Long overflow flag not set");

  property p_lane_contention_flag_read;
    arvalid && arready && araddr[11:2] == `ERRF_IDX
      |=> rvalid && rdata[`BIT_LANE_CONTENTION_FLAG] == $past(evt.lane_contention);
  endproperty
  a_lane_contention_flag_read: assert property (p_lane_contention_flag_read)
    else $error("Contention bit does not follow detector");

  property p_vcm_set;
    evt.channel_id_mismatch |=> err_q[`BIT_VCM];
  endproperty
  a_vcm_set: assert property (p_vcm_set)
    else $error("Channel mismatch flag not set");

  property p_dly_write;
    wr_fire && wr_sel_ff == `DLY_IDX && wstrb_ff == 2'b11
      |=> delay_ff == $past(wdata_ff);
  endproperty
  a_dly_write: assert property (p_dly_write)
    else $error("Delay register not written");

  property p_rsvd_zero;
    arvalid && arready && araddr[11:2] == `ERRF_IDX
      |=> (rdata & `ERRF_RSVD_MASK) == 32'h0000_0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Reserved error bits read nonzero");

  property p_bresp;
    wr_fire |=> bvalid ##0 bresp == $past(wr_hit ? `RESP_OKAY : `RESP_SLVERR);
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("Write response missing or wrong");

  c_crc_clear: cover property (err_q[`BIT_CRC] ##[1:20] !err_q[`BIT_CRC]);
  c_dly_write: cover property (wr_fire && wr_sel_ff == `DLY_IDX);
  c_irq: cover property ($rose(irq));
  c_set_clear: cover property (|(err_set & err_clr));
endmodule // link_err_regs
`default_nettype wire

// ### bench/link_peer_model.sv
// Display peripheral model reporting link faults as event pulses
`default_nettype none
module link_peer_model
  import link_err_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire link_evt_t fault,
  input wire logic contended,
  output var link_evt_t evt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Faults last one cycle so each one sets a flag once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      evt <= '0;
    end else begin
      evt <= fault;
      // Contention stays up as long as the lane is fought over
      evt.lane_contention <= contended;
    end
  end
endmodule // link_peer_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the link error and delay register block
`include "link_err_consts.svh"
`default_nettype none
module testbench
  import link_err_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [6:0] ev;
    logic [15:0] flag;
  } row_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, hs_entry_start = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic check_disable, hs_prepare_on, hs_zero_on, irq;
  link_evt_t evt, fault = '0;
  logic contended = 1'b0;
  int num_errors = 0, total_checks = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  row_t rows[6] = '{'{7'h40, 16'h0400}, '{7'h20, 16'h0200},
    '{7'h10, 16'h0100}, '{7'h08, 16'h0080}, '{7'h04, 16'h0010},
    '{7'h01, 16'h0001}};
  logic [15:0] dly_rows[3] = '{16'h0102, 16'h0000, 16'h0300};

  always #2 clock = ~clock;

  link_err_regs u_link_err_regs (.clock(clock), .nrst(nrst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .evt(evt),
    .hs_entry_start(hs_entry_start), .check_disable(check_disable),
    .hs_prepare_on(hs_prepare_on), .hs_zero_on(hs_zero_on), .irq(irq));
  link_peer_model u_link_peer_model (.clock(clock), .nrst(nrst),
    .fault(fault), .contended(contended), .evt(evt));

  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hung();
    num_errors++;
    $display("Error bus wait expected answer seen none");
    summarize();
  endtask

  // Write with both halves offered together; bready held until answer
  task automatic wr(input logic [9:0] i, input logic [31:0] d,
                    output logic [1:0] r);
    logic ha, hw, hb, done;
    done = 1'b0;
    @(posedge clock);
    awaddr <= ad(i);
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(negedge clock);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge clock);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) hung();
  endtask

  task automatic rdr(input logic [9:0] i, output logic [31:0] d,
                     output logic [1:0] r);
    logic ha, done;
    done = 1'b0;
    @(posedge clock);
    araddr <= ad(i);
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(negedge clock);
      ha = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ha) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    if (!done) hung();
  endtask

  task automatic rchk(input logic [9:0] i, input logic [31:0] exp);
    rdr(i, rd, rs);
    chk("read data", exp, rd);
    chk("read resp", `RESP_OKAY, rs);
  endtask

  task automatic pulse(input logic [6:0] v);
    @(posedge clock);
    fault <= v;
    @(posedge clock);
    fault <= '0;
    repeat (3) @(posedge clock);
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  task automatic hs_run(input logic [15:0] d);
    int np, nz;
    np = 0;
    nz = 0;
    wr(`DLY_IDX, {16'h0, d}, rs);
    @(posedge clock);
    hs_entry_start <= 1'b1;
    @(posedge clock);
    hs_entry_start <= 1'b0;
    for (int n = 0; n < 1100; n++) begin
      @(negedge clock);
      np += hs_prepare_on;
      nz += hs_zero_on;
    end
    chk("prepare cycles", (4 + d[7:0]) * `NIBBLE_DIV, np);
    chk("zero cycles", d[15:8] * `NIBBLE_DIV, nz);
  endtask

  initial begin
    do_reset();
    rchk(`ERRF_IDX, 32'h0);
    rchk(`DLY_IDX, {16'h0, `DLY_RESET});
    // Set, hold through a zero write, clear by writing one
    foreach (rows[k]) begin
      pulse(rows[k].ev);
      rchk(`ERRF_IDX, {16'h0, rows[k].flag});
      wr(`ERRF_IDX, 32'h0, rs);
      rchk(`ERRF_IDX, {16'h0, rows[k].flag});
      wr(`ERRF_IDX, {16'h0, rows[k].flag}, rs);
      rchk(`ERRF_IDX, 32'h0);
    end
    $display("test event rows done");
    // All events but contention at once, then reserved and read-only bits
    pulse(7'h7d);
    rchk(`ERRF_IDX, 32'h0791);
    wr(`ERRF_IDX, 32'hffff_ffff, rs);
    rchk(`ERRF_IDX, 32'h0);
    contended <= 1'b1;
    repeat (3) @(posedge clock);
    rchk(`ERRF_IDX, 32'h0004);
    wr(`ERRF_IDX, 32'h0004, rs);
    rchk(`ERRF_IDX, 32'h0004);
    contended <= 1'b0;
    repeat (3) @(posedge clock);
    rchk(`ERRF_IDX, 32'h0);
    $display("test reserved and contention done");
    // Checks disabled: CRC and ECC events leave no trace
    wr(`CTRL_IDX, 32'h1, rs);
    chk("check disable", 1'b1, check_disable);
    pulse(7'h70);
    rchk(`ERRF_IDX, 32'h0);
    wr(`CTRL_IDX, 32'h0, rs);
    pulse(7'h40);
    rchk(`ERRF_IDX, 32'h0400);
    wr(`ERRF_IDX, 32'h0400, rs);
    $display("test check disable done");
    // Interrupt raised, masked and cleared
    wr(`IRQ_CLR_IDX, 32'hffff, rs);
    rchk(`IRQ_ST_IDX, 32'h0);
    wr(`IRQ_EN_IDX, 32'h0400, rs);
    rchk(`IRQ_EN_IDX, 32'h0400);
    pulse(7'h01);
    chk("irq masked", 1'b0, irq);
    pulse(7'h40);
    chk("irq raised", 1'b1, irq);
    wr(`IRQ_CLR_IDX, 32'h0400, rs);
    repeat (2) @(posedge clock);
    chk("irq cleared", 1'b0, irq);
    rchk(`IRQ_ST_IDX, 32'h0001);
    wr(`IRQ_CLR_IDX, 32'h0001, rs);
    $display("test interrupt done");
    // Unmapped place answers with an error and no data
    wr(10'h004, 32'h1234, rs);
    chk("write resp", `RESP_SLVERR, rs);
    rdr(10'h004, rd, rs);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped resp", `RESP_SLVERR, rs);
    // Delay register round trip, upper data bits ignored
    wr(`DLY_IDX, 32'hffff_a55a, rs);
    rchk(`DLY_IDX, 32'h0000_a55a);
    foreach (dly_rows[k]) hs_run(dly_rows[k]);
    $display("test delay timing done");
    // Second reset in mid-run restores the defaults
    pulse(7'h40);
    do_reset();
    rchk(`DLY_IDX, {16'h0, `DLY_RESET});
    rchk(`ERRF_IDX, 32'h0);
    $display("test second reset done");
    summarize();
  end
endmodule // testbench
`default_nettype wire
